// ### pkg/cpr_pkg.sv
package cpr_pkg;

  // ------------------------------------------------------------------
  // command and response type codes
  // ------------------------------------------------------------------
  localparam logic [7:0] CPR_CMD_CAP   = 8'h16;
  localparam logic [7:0] CPR_CMD_PARAM = 8'h17;
  localparam logic [7:0] CPR_RSP_FLAG  = 8'h80;

  // ------------------------------------------------------------------
  // filter counts fixed by this channel's hardware
  // ------------------------------------------------------------------
  localparam logic [7:0] CPR_CNT_UC   = 8'h02;
  localparam logic [7:0] CPR_CNT_MC   = 8'h02;
  localparam logic [7:0] CPR_CNT_MIX  = 8'h04;
  localparam logic [7:0] CPR_CNT_VLAN = 8'h04;
  localparam logic [7:0] CPR_MAX_ADDR = 8'h08;
  localparam logic [7:0] CPR_MAX_VLAN = 8'h0F;
  localparam int         CPR_NUM_MAC  = 8;
  localparam int         CPR_NUM_VLAN = 4;

  // ------------------------------------------------------------------
  // byte offsets inside the response packet
  // ------------------------------------------------------------------
  localparam int         CPR_FIRST_BYTE  = 16;
  localparam int         CPR_FIXED_END   = 48;
  localparam int         CPR_TAIL_RAW    = 6 * CPR_NUM_MAC + 2 * CPR_NUM_VLAN;
  localparam int         CPR_TAIL_PAD    = (4 - (CPR_TAIL_RAW % 4)) % 4;
  localparam int         CPR_TAIL_BYTES  = CPR_TAIL_RAW + CPR_TAIL_PAD;
  localparam int         CPR_PARAM_END   = CPR_FIXED_END + CPR_TAIL_BYTES;
  localparam int         CPR_VEC_W       = 8 * (CPR_PARAM_END - CPR_FIRST_BYTE);
  localparam int         CPR_TAIL_W      = 8 * CPR_TAIL_BYTES;
  localparam logic [7:0] CPR_IDX_FIRST   = 8'h10;
  localparam logic [7:0] CPR_IDX_FLAGS0  = 8'h14;
  localparam logic [7:0] CPR_IDX_FLAGS3  = 8'h17;
  localparam logic [7:0] CPR_IDX_BCAST3  = 8'h23;
  localparam logic [7:0] CPR_IDX_VCOUNT  = 8'h28;
  localparam logic [7:0] CPR_IDX_MIXCNT  = 8'h29;
  localparam logic [7:0] CPR_IDX_VMODE   = 8'h2E;
  localparam logic [7:0] CPR_IDX_TAIL    = 8'h30;
  localparam logic [7:0] CPR_IDX_CAP_LST = 8'h2F;
  localparam logic [7:0] CPR_IDX_PAR_LST = 8'(CPR_PARAM_END - 1);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    CPR_IDLE = 2'b01,
    CPR_SEND = 2'b10
  } cpr_state_e;

  typedef struct packed {
    cpr_state_e state;
    logic       is_param;
    logic [7:0] idx;
    logic [7:0] data;
    logic [7:0] rtype;
    logic       ignored;
  } cpr_state_s;

  localparam logic [7:0] CPR_RST_BYTE = 8'h00;

endpackage

// ### sim/capability_parameter_responder_tb.sv
`timescale 1ns/1ns
module capability_parameter_responder_tb;
  import cpr_pkg::*;
  logic clk_i, rst_b_i, stall, slow, cmd_valid, cmd_ok, cmd_ready, cmd_ign, rsp_valid, rsp_last, rsp_ready;
  logic [7:0] cmd_type, rsp_data, rsp_type, chan, mflag, vmode, flow;
  logic [4:0] cflags;
  logic [1:0] vsup;
  logic [15:0] vflag;
  logic [31:0] bcap, mcap, bufb, aenc, link, bset, cfg, aens;
  logic [383:0] mac;
  logic [63:0] tag;
  int seed = 58882;
  int err_count = 0;
  int checks_done = 0;

  cpr_responder dut_u (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .cmd_valid_i(cmd_valid), .cmd_type_i(cmd_type), .cmd_ok_i(cmd_ok),
    .cmd_ready_o(cmd_ready), .cmd_ignored_o(cmd_ign), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data),
    .rsp_type_o(rsp_type), .rsp_last_o(rsp_last), .rsp_ready_i(rsp_ready),
    .cap_hw_arb_i(cflags[0]), .cap_os_present_i(cflags[1]), .cap_fc_to_mgmt_i(cflags[2]),
    .cap_fc_from_mgmt_i(cflags[3]), .cap_all_mcast_i(cflags[4]), .cap_bcast_filters_i(bcap),
    .cap_mcast_filters_i(mcap), .cap_buffer_bytes_i(bufb), .cap_async_event_notice_i(aenc),
    .cap_tagged_plus_untagged_mode_i(vsup[0]), .cap_any_tag_plus_untagged_mode_i(vsup[1]),
    .cap_channel_count_i(chan), .set_mac_flags_i(mflag), .set_vlan_flags_i(vflag), .set_link_i(link),
    .set_bcast_i(bset), .set_config_flags_i(cfg), .set_vlan_mode_i(vmode), .set_flow_ctrl_i(flow),
    .set_async_event_notice_i(aens), .set_mac_addr_i(mac), .set_vlan_tag_i(tag));

  cpr_mgmt_model mgmt_u (
    .clk_i(clk_i), .cmd_ignored_i(cmd_ign), .rsp_valid_i(rsp_valid), .rsp_data_i(rsp_data),
    .rsp_type_i(rsp_type), .rsp_last_i(rsp_last), .stall_i(stall), .cmd_valid_o(cmd_valid),
    .cmd_type_o(cmd_type), .cmd_ok_o(cmd_ok), .rsp_ready_o(rsp_ready));

  // ------------------------------------------------------------------
  // expected bytes, indexed by packet byte number
  // ------------------------------------------------------------------
  function automatic logic [7:0] exp_cap(int k);
    logic [255:0] v;
    v = {32'h0, 27'h0, cflags, bcap, mcap, bufb, aenc, CPR_CNT_VLAN, CPR_CNT_MIX, CPR_CNT_MC, CPR_CNT_UC,
         16'h0, 5'h0, vsup, 1'h1, chan};
    return v[8*(47-k)+:8];
  endfunction

  // unsupported broadcast settings read as zero, hence the mask with the capability word
  function automatic logic [7:0] exp_par(int k);
    logic [255:0] h;
    int j;
    h = {32'h0, CPR_CNT_UC + CPR_CNT_MC + CPR_CNT_MIX, 16'h0, mflag, CPR_CNT_VLAN, 8'h0, 12'h0, vflag[3:0],
         link, bset & bcap, cfg, vmode, flow, 16'h0, aens};
    j = k - 48;
    if (k < 48) return h[8*(47-k)+:8];
    if (k < 96) return mac[48*(j/6)+8*(5-j%6)+:8];
    return tag[16*((j-48)/2)+8*(1-(j-48)%2)+:8];
  endfunction

  // first two rounds pin every strap to all ones, then all zeros
  function automatic logic [31:0] rnd(int it);
    return (it == 0) ? 32'hFFFFFFFF : (it == 1) ? 32'h0 : $random(seed);
  endfunction

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic check(input logic [31:0] g, input logic [31:0] e, input string what);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic shake(input int it);
    cflags <= 5'(rnd(it));
    vsup   <= 2'(rnd(it));
    chan   <= 8'(rnd(it));
    mflag  <= 8'(rnd(it));
    vmode  <= 8'(rnd(it));
    flow   <= 8'(rnd(it));
    vflag  <= 16'(rnd(it));
    {bcap, mcap, bufb, aenc} <= {rnd(it), rnd(it), rnd(it), rnd(it)};
    {link, bset, cfg, aens}  <= {rnd(it), rnd(it), rnd(it), rnd(it)};
    for (int i = 0; i < 12; i++) mac[32*i+:32] <= rnd(it);
    tag <= {rnd(it), rnd(it)};
  endtask

  // one query, with random stalls only while slow is set, then the whole byte stream is compared
  task automatic run(input logic [7:0] t, input int n);
    int k;
    mgmt_u.got.delete();
    mgmt_u.last_len = 0;
    mgmt_u.send(t, 1'b1);
    k = 0;
    while (mgmt_u.last_len == 0 && k < 400) begin
      @(posedge clk_i);
      stall <= slow && (($random(seed) & 1) != 0);
      k++;
    end
    if (mgmt_u.last_len == 0) begin
      err_count++;
      $display("wrong value at %0t: response never finished", $time);
      give_verdict();
    end else begin
      check(mgmt_u.last_len, n, "length at last byte");
      check(mgmt_u.got.size(), n, "byte count");
      check(mgmt_u.last_type, t | CPR_RSP_FLAG, "response type");
      for (int i = 0; i < n; i++)
        check(mgmt_u.got[i], (t == CPR_CMD_CAP) ? exp_cap(i + 16) : exp_par(i + 16), "byte");
    end
  endtask

  // ------------------------------------------------------------------
  // clock, reset, sequence
  // ------------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  initial begin
    logic [7:0] bad_t [2];
    logic       bad_ok [2];
    int         ign0;
    bad_t  = '{CPR_CMD_PARAM, 8'h55};
    bad_ok = '{1'b0, 1'b1};
    rst_b_i = 1'b0;
    stall = 1'b0;
    slow = 1'b0;
    shake(1);
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    #1;
    check(cmd_ready, 1'b1, "ready after reset");
    check(rsp_valid, 1'b0, "valid after reset");
    check(rsp_type, 8'h00, "type after reset");
    check(rsp_data, 8'h00, "data after reset");
    check({rsp_last, cmd_ign}, 2'b00, "last and ignored after reset");
    @(posedge clk_i);
    for (int it = 0; it < 10; it++) begin
      shake(it);
      slow <= (it % 2) == 1;
      @(posedge clk_i);
      run(CPR_CMD_CAP, 32);
      check(32'(mgmt_u.got[24] <= CPR_MAX_VLAN), 1, "vlan filter count");
      check(32'((mgmt_u.got[27] + mgmt_u.got[25]) >= 1), 1, "unicast capable");
      check(32'((mgmt_u.got[27] + mgmt_u.got[26] + mgmt_u.got[25]) <= 8), 1, "address total");
      run(CPR_CMD_PARAM, 88);
    end
    // bad checksum and an unknown code are both dropped without a reply
    for (int b = 0; b < 2; b++) begin
      ign0 = mgmt_u.ign_cnt;
      mgmt_u.got.delete();
      mgmt_u.send(bad_t[b], bad_ok[b]);
      repeat (4) @(posedge clk_i);
      check(mgmt_u.ign_cnt - ign0, 1, "ignored pulse count");
      check(mgmt_u.got.size(), 0, "no reply bytes");
    end
    run(CPR_CMD_PARAM, 88);
    give_verdict();
  end

  // overall limit against a hang anywhere
  initial begin
    repeat (100000) @(posedge clk_i);
    err_count++;
    $display("wrong value at %0t: run limit reached", $time);
    give_verdict();
  end
endmodule

// ### sim/cpr_mgmt_model.sv
`timescale 1ns/1ns
// management controller: issues queries, consumes response bytes
module cpr_mgmt_model
  import cpr_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       cmd_ignored_i,
  input  wire logic       rsp_valid_i,
  input  wire logic [7:0] rsp_data_i,
  input  wire logic [7:0] rsp_type_i,
  input  wire logic       rsp_last_i,
  input  wire logic       stall_i,
  output logic            cmd_valid_o,
  output logic [7:0]      cmd_type_o,
  output logic            cmd_ok_o,
  output logic            rsp_ready_o
);
  logic [7:0] got[$];
  logic [7:0] last_type;
  int         last_len;
  int         ign_cnt;

  initial begin
    cmd_valid_o = 1'b0;
    cmd_type_o  = 8'h00;
    cmd_ok_o    = 1'b0;
    last_type   = 8'h00;
    last_len    = 0;
    ign_cnt     = 0;
  end

  // backpressure follows the bench's stall stream, so slow replies are exercised
  assign rsp_ready_o = !stall_i;

  // sample at the edge: values seen here are those from before the edge
  always @(posedge clk_i) begin
    if (cmd_ignored_i) ign_cnt++;
    if (rsp_valid_i && rsp_ready_o) begin
      got.push_back(rsp_data_i);
      if (rsp_last_i) begin
        last_len  = got.size();
        last_type = rsp_type_i;
      end
    end
  end

  // called just after an edge while the block is idle, so ready is high at the taking edge
  task automatic send(input logic [7:0] t, input logic ok);
    cmd_valid_o <= 1'b1;
    cmd_type_o  <= t;
    cmd_ok_o    <= ok;
    @(posedge clk_i);
    cmd_valid_o <= 1'b0;
    cmd_type_o  <= ~t; // released lines must not keep the old code
    cmd_ok_o    <= ~ok;
  endtask
endmodule

// ### verilog/cpr_responder.sv
`timescale 1ns/1ns
module cpr_responder
  import cpr_pkg::*;
(
  input  wire logic                      clk_i,
  input  wire logic                      rst_b_i,
  // command side
  input  wire logic                      cmd_valid_i,
  input  wire logic [7:0]                cmd_type_i,
  input  wire logic                      cmd_ok_i,
  output logic                           cmd_ready_o,
  output logic                           cmd_ignored_o,
  // response byte stream, from byte 16 to the byte before the checksum
  output logic                           rsp_valid_o,
  output logic [7:0]                     rsp_data_o,
  output logic [7:0]                     rsp_type_o,
  output logic                           rsp_last_o,
  input  wire logic                      rsp_ready_i,
  // capability straps
  input  wire logic                      cap_hw_arb_i,
  input  wire logic                      cap_os_present_i,
  input  wire logic                      cap_fc_to_mgmt_i,
  input  wire logic                      cap_fc_from_mgmt_i,
  input  wire logic                      cap_all_mcast_i,
  input  wire logic [31:0]               cap_bcast_filters_i,
  input  wire logic [31:0]               cap_mcast_filters_i,
  input  wire logic [31:0]               cap_buffer_bytes_i,
  input  wire logic [31:0]               cap_async_event_notice_i,
  input  wire logic                      cap_tagged_plus_untagged_mode_i,
  input  wire logic                      cap_any_tag_plus_untagged_mode_i,
  input  wire logic [7:0]                cap_channel_count_i,
  // current settings held by the command handlers
  input  wire logic [7:0]                set_mac_flags_i,
  input  wire logic [15:0]               set_vlan_flags_i,
  input  wire logic [31:0]               set_link_i,
  input  wire logic [31:0]               set_bcast_i,
  input  wire logic [31:0]               set_config_flags_i,
  input  wire logic [7:0]                set_vlan_mode_i,
  input  wire logic [7:0]                set_flow_ctrl_i,
  input  wire logic [31:0]               set_async_event_notice_i,
  input  wire logic [48*CPR_NUM_MAC-1:0]  set_mac_addr_i,
  input  wire logic [16*CPR_NUM_VLAN-1:0] set_vlan_tag_i
);

  // ------------------------------------------------------------------
  // byte picking
  // ------------------------------------------------------------------

  // both response images are big-endian vectors starting at byte 16
  function automatic logic [7:0] pick_byte(input logic [CPR_VEC_W-1:0] vec, input logic [7:0] idx);
    logic [7:0] ofs;
    ofs = idx - CPR_IDX_FIRST;
    pick_byte = vec[(CPR_VEC_W - 1) - 8 * int'(ofs) -: 8];
  endfunction

  // ------------------------------------------------------------------
  // query decode
  // ------------------------------------------------------------------

  // the type decode is needed both to accept a query and to pick its image
  function automatic logic is_param_code(input logic [7:0] code);
    is_param_code = (code == CPR_CMD_PARAM);
  endfunction

  function automatic logic is_query_code(input logic [7:0] code);
    is_query_code = (code == CPR_CMD_CAP) || is_param_code(code);
  endfunction

  // ------------------------------------------------------------------
  // capability image
  // ------------------------------------------------------------------

  logic [31:0]          cap_flags;
  logic [7:0]           vmode_sup;
  logic [255:0]         cap_img;
  logic [CPR_VEC_W-1:0] cap_vec;

  // reserved flag bits are tied low so stray straps never leak out
  assign cap_flags = {27'h0000000,
                      cap_all_mcast_i,
                      cap_fc_from_mgmt_i,
                      cap_fc_to_mgmt_i,
                      cap_os_present_i,
                      cap_hw_arb_i};

  // tagged-only filtering is mandatory, so its bit is a constant
  assign vmode_sup = {5'h00,
                      cap_any_tag_plus_untagged_mode_i,
                      cap_tagged_plus_untagged_mode_i,
                      1'b1};

  // filter counts are fixed at build time and sit within the limits
  assign cap_img = {16'h0000, 16'h0000,
                    cap_flags,
                    cap_bcast_filters_i,
                    cap_mcast_filters_i,
                    cap_buffer_bytes_i,
                    cap_async_event_notice_i,
                    CPR_CNT_VLAN,
                    CPR_CNT_MIX,
                    CPR_CNT_MC,
                    CPR_CNT_UC,
                    16'h0000,
                    vmode_sup,
                    cap_channel_count_i};

  assign cap_vec = {cap_img, {(CPR_VEC_W - 256){1'b0}}};

  // ------------------------------------------------------------------
  // parameter image
  // ------------------------------------------------------------------

  logic [255:0]          par_img;
  logic [CPR_TAIL_W-1:0] tail;
  logic [CPR_VEC_W-1:0]  par_vec;
  logic [7:0]            mac_flags;
  logic [15:0]           vlan_flags;

  // flags of filters that do not exist read as zero
  assign mac_flags  = set_mac_flags_i & 8'((1 << CPR_NUM_MAC) - 1);
  assign vlan_flags = set_vlan_flags_i & 16'((1 << CPR_NUM_VLAN) - 1);

  // broadcast settings are masked by what the channel implements
  assign par_img = {16'h0000, 16'h0000,
                    8'(CPR_NUM_MAC), 16'h0000, mac_flags,
                    8'(CPR_NUM_VLAN), 8'h00, vlan_flags,
                    set_link_i,
                    set_bcast_i & cap_bcast_filters_i,
                    set_config_flags_i,
                    set_vlan_mode_i, set_flow_ctrl_i, 16'h0000,
                    set_async_event_notice_i};

  // address entries back to back in filter order, unicast first,
  // then multicast, then mixed; tags follow, then pad to a word
  genvar gi;
  generate
    for (gi = 0; gi < CPR_NUM_MAC; gi++) begin : g_mac
      assign tail[(CPR_TAIL_W - 1) - 48 * gi -: 48] = set_mac_addr_i[48 * gi +: 48];
    end
    for (gi = 0; gi < CPR_NUM_VLAN; gi++) begin : g_vlan
      assign tail[(CPR_TAIL_W - 1) - 48 * CPR_NUM_MAC - 16 * gi -: 16] = set_vlan_tag_i[16 * gi +: 16];
    end
    if (CPR_TAIL_PAD > 0) begin : g_pad
      assign tail[8 * CPR_TAIL_PAD - 1:0] = '0;
    end
  endgenerate

  assign par_vec = {par_img, tail};

  // ------------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------------

  cpr_state_s st_r;
  cpr_state_s st_nxt;
  logic       take;
  logic       good;
  logic       last;

  assign take = cmd_valid_i && cmd_ready_o;
  // only well-formed queries of the two kinds are answered here
  assign good = cmd_ok_i && is_query_code(cmd_type_i);
  // straps and settings are read live rather than copied at the start: this saves
  // a wide snapshot register, but a value that moves mid-answer changes later bytes
  assign last = st_r.is_param ? (st_r.idx == CPR_IDX_PAR_LST) : (st_r.idx == CPR_IDX_CAP_LST);

  // next state: start on a good query, advance one byte per accepted beat
  always_comb begin
    st_nxt         = st_r;
    st_nxt.ignored = 1'b0;
    case (st_r.state)
      CPR_IDLE: begin
        if (take && good) begin
          st_nxt.state    = CPR_SEND;
          st_nxt.is_param = is_param_code(cmd_type_i);
          st_nxt.rtype    = cmd_type_i | CPR_RSP_FLAG;
          st_nxt.idx      = CPR_IDX_FIRST;
        end else if (take) begin
          st_nxt.ignored = 1'b1;
        end
      end
      CPR_SEND: begin
        if (rsp_ready_i && last) begin
          st_nxt.state = CPR_IDLE;
        end else if (rsp_ready_i) begin
          st_nxt.idx = st_r.idx + 8'h01;
        end
      end
      default: begin
        st_nxt.state = CPR_IDLE;
      end
    endcase
    // data register follows the index so the byte is ready with valid
    st_nxt.data = st_nxt.is_param ? pick_byte(par_vec, st_nxt.idx) : pick_byte(cap_vec, st_nxt.idx);
  end

  // single state register
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st_r.state    <= CPR_IDLE;
      st_r.is_param <= 1'b0;
      st_r.idx      <= CPR_IDX_FIRST;
      st_r.data     <= CPR_RST_BYTE;
      st_r.rtype    <= CPR_RST_BYTE;
      st_r.ignored  <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------

  // one response at a time; a new query waits until the last byte leaves
  assign cmd_ready_o   = (st_r.state == CPR_IDLE);
  assign cmd_ignored_o = st_r.ignored;
  assign rsp_valid_o   = (st_r.state == CPR_SEND);
  assign rsp_data_o    = st_r.data;
  assign rsp_type_o    = st_r.rtype;
  assign rsp_last_o    = rsp_valid_o && last;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  cap_type_a: assert property (take && good && cmd_type_i == CPR_CMD_CAP |=>
                               rsp_valid_o && rsp_type_o == 8'h96 && rsp_data_o == 8'h00)
    else $error("capability answer has wrong type");

  param_type_a: assert property (take && good && cmd_type_i == CPR_CMD_PARAM |=>
                                 rsp_valid_o && rsp_type_o == 8'h97)
    else $error("parameter answer has wrong type");

  bad_cmd_a: assert property (take && !good |=> !rsp_valid_o && cmd_ignored_o ##1 !cmd_ignored_o)
    else $error("bad command was answered");

  flag_rsv_a: assert property (rsp_valid_o && !st_r.is_param && st_r.idx == CPR_IDX_FLAGS0 |->
                               rsp_data_o == 8'h00)
    else $error("reserved capability flag bits not zero");

  flag_bits_a: assert property (rsp_valid_o && !st_r.is_param && st_r.idx == CPR_IDX_FLAGS3 |->
                                rsp_data_o == {3'h0, cap_all_mcast_i, cap_fc_from_mgmt_i,
                                               cap_fc_to_mgmt_i, cap_os_present_i, cap_hw_arb_i})
    else $error("capability flag byte wrong");

  vmode_a: assert property (rsp_valid_o && !st_r.is_param && st_r.idx == CPR_IDX_VMODE |->
                            rsp_data_o[0] && rsp_data_o[7:3] == 5'h00)
    else $error("VLAN mode support byte wrong");

  vcount_a: assert property (rsp_valid_o && !st_r.is_param && st_r.idx == CPR_IDX_VCOUNT |->
                             rsp_data_o <= CPR_MAX_VLAN)
    else $error("VLAN filter count above limit");

  addr_sum_a: assert property (rsp_valid_o && !st_r.is_param && st_r.idx == CPR_IDX_MIXCNT |->
                               rsp_data_o + CPR_CNT_MC + CPR_CNT_UC <= CPR_MAX_ADDR &&
                               rsp_data_o + CPR_CNT_UC >= 8'h01)
    else $error("address filter counts out of range");

  first_mac_a: assert property (rsp_valid_o && st_r.is_param && st_r.idx == CPR_IDX_TAIL |->
                                rsp_data_o == set_mac_addr_i[47:40])
    else $error("first address entry misplaced");

  bcast_set_a: assert property (rsp_valid_o && st_r.is_param && st_r.idx == CPR_IDX_BCAST3 |->
                                rsp_data_o == (set_bcast_i[7:0] & cap_bcast_filters_i[7:0]))
    else $error("unsupported broadcast setting not zero");

  length_a: assert property (rsp_last_o && rsp_ready_i |->
                             st_r.idx == (st_r.is_param ? CPR_IDX_PAR_LST : CPR_IDX_CAP_LST)
                             ##1 cmd_ready_o && !rsp_valid_o)
    else $error("response length wrong");

  hold_a: assert property (rsp_valid_o && !rsp_ready_i |=> rsp_valid_o && $stable(rsp_data_o) && $stable(st_r.idx))
    else $error("byte changed while stalled");

  // byte checks below, mac_count_a aside, compare against live inputs, so they rely on the
  // straps and settings staying put for the length of an answer

  ready_busy_a: assert property (rsp_valid_o |-> !cmd_ready_o && !cmd_ignored_o)
    else $error("query accepted while answering");

  drop_quiet_a: assert property (cmd_ignored_o |-> !rsp_valid_o && cmd_ready_o)
    else $error("dropped query started an answer");

  type_hold_a: assert property (rsp_valid_o && $past(rsp_valid_o) |-> $stable(rsp_type_o))
    else $error("response type moved mid answer");

  vmode_opt_a: assert property (rsp_valid_o && !st_r.is_param && st_r.idx == CPR_IDX_VMODE |->
                                rsp_data_o[2:1] == {cap_any_tag_plus_untagged_mode_i,
                                                    cap_tagged_plus_untagged_mode_i})
    else $error("optional VLAN mode bits wrong");

  chan_count_a: assert property (rsp_valid_o && !st_r.is_param && st_r.idx == CPR_IDX_CAP_LST |->
                                 rsp_data_o == cap_channel_count_i)
    else $error("channel count byte wrong");

  // byte 35 of the capability image is the low byte of the buffering field
  buf_low_a: assert property (rsp_valid_o && !st_r.is_param && st_r.idx == CPR_IDX_BCAST3 |->
                              rsp_data_o == cap_buffer_bytes_i[7:0])
    else $error("buffering byte wrong");

  // byte 20 of the parameter image counts every address entry that follows
  mac_count_a: assert property (rsp_valid_o && st_r.is_param && st_r.idx == CPR_IDX_FLAGS0 |->
                                rsp_data_o == CPR_CNT_UC + CPR_CNT_MC + CPR_CNT_MIX)
    else $error("address entry count wrong");

  mac_flag_a: assert property (rsp_valid_o && st_r.is_param && st_r.idx == CPR_IDX_FLAGS3 |->
                               rsp_data_o == set_mac_flags_i)
    else $error("address flag byte wrong");

  // with no pad the stream ends on the low byte of the last tag
  last_tag_a: assert property (rsp_valid_o && st_r.is_param && st_r.idx == CPR_IDX_PAR_LST |->
                               rsp_data_o == set_vlan_tag_i[16 * CPR_NUM_VLAN - 9 -: 8])
    else $error("last parameter byte wrong");

  cap_done_c: cover property (rsp_last_o && rsp_ready_i && !st_r.is_param);
  par_done_c: cover property (rsp_last_o && rsp_ready_i && st_r.is_param);
  ignored_c:  cover property (cmd_ignored_o);
  stall_c:    cover property (rsp_valid_o && !rsp_ready_i ##1 rsp_valid_o && rsp_ready_i);
  retry_c:    cover property (cmd_ignored_o ##[1:8] rsp_valid_o);

endmodule
